// *** core/inertial_delta_integrator.sv ***
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Small synchronous FIFO; depth must be a power of two.
module sample_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH]; // Storage, no reset needed.
    logic [AW:0] wr_ptr_ff; // Extra bit tells full from empty.
    logic [AW:0] rd_ptr_ff;
    logic push;
    logic pop;

    assign level_o = wr_ptr_ff - rd_ptr_ff;
    assign in_ready_o = (level_o != (AW+1)'(DEPTH));
    assign out_valid_o = (wr_ptr_ff != rd_ptr_ff);
    assign out_data_o = mem_ff[rd_ptr_ff[AW-1:0]];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Write side.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr_ff <= '0;
        end else if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
        end
    end

    // Data array is written only on an accepted push.
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
        end
    end

    // Read side.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_ptr_ff <= '0;
        end else if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end
endmodule

module inertial_delta_integrator
    import inertial_delta_pkg::*;
#(
    parameter int unsigned SAMPLE_TICK_CYCLES = TICK_CYCLES,
    parameter logic [15:0] PART_CODE = 16'h5a5a // Arbitrary value.
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    input wire logic ext_clk_i,
    output logic sample_req_o,
    input wire logic sample_valid_i,
    output logic sample_ready_o,
    input wire sample_t sample_i,
    output logic block_read_start_o,
    output logic data_ready_o
);

    // Register file state.
    logic [15:0] decimation_setting_ff; // Samples per result minus one.
    logic ext_sel_ff; // High selects the external sample clock.
    logic [NUM_AXES-1:0][15:0] gain_ff; // User gain per axis.
    logic [NUM_AXES-1:0][15:0] bias_ff; // User bias per axis.

    // Bus handshake state.
    logic wait_ff; // Drives waitrequest; high while idle.
    logic [31:0] rdata_ff; // Read data, captured at acceptance.
    logic [1:0] resp_ff; // Response code for the access.
    logic block_read_ff; // One-cycle burst launch pulse.
    logic req;
    logic accept; // First edge of a request.
    logic done; // Edge at which the master sees waitrequest low.
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;

    // Sample timing state.
    logic [15:0] tick_cnt_ff; // Divider for the internal rate.
    logic ext_d_ff; // Previous external clock level.
    logic sample_req_ff; // One pulse per sample period.
    logic int_tick;
    logic ext_edge;

    // Buffer and chain state.
    logic ready_ff; // Registered ready toward the front end.
    logic [$clog2(FIFO_DEPTH):0] fifo_level;
    logic fifo_valid;
    logic fifo_pop;
    sample_t fifo_data;
    chain_state_t state_ff;
    sample_t raw_ff; // Sample under correction.
    logic [NUM_AXES-1:0][CORR_W-1:0] corr_ff; // Corrected sample.
    logic [NUM_AXES-1:0][CORR_W-1:0] prev_ff; // Previous corrected sample.
    logic [NUM_AXES-1:0][DELTA_W-1:0] acc_ff; // Running period sum.
    logic [NUM_AXES-1:0][DELTA_W-1:0] delta_ff; // Published results.
    logic [15:0] dec_cnt_ff; // Samples taken in this period minus one.
    logic period_end;
    logic ready_pulse_ff;
    logic [15:0] update_cnt_ff; // Results published since reset.

    assign req = avs_read_i || avs_write_i;
    assign accept = req && wait_ff;
    assign done = req && !wait_ff;

    // Byte lanes 0 and 1 carry the 16-bit contents.
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // Address decode for reads; unmapped words read as zero.
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (avs_address_i)
            OFS_PART_NUMBER_CODE: begin
                rd_word = {16'h0000, PART_CODE};
            end
            OFS_DECIMATION: begin
                rd_word = {16'h0000, decimation_setting_ff};
            end
            OFS_CONTROL: begin
                rd_word = {31'h0000_0000, ext_sel_ff};
            end
            OFS_BLOCK_READ: begin
                // Reads return zero; the side effect is the point.
                rd_word = 32'h0000_0000;
            end
            OFS_STATUS: begin
                rd_word = {13'h0000, fifo_level, update_cnt_ff};
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
        for (int i = 0; i < NUM_AXES; i++) begin
            // Lower word first, then upper word of each result.
            if (avs_address_i == 8'(OFS_OUTPUT_BASE + 8 * i)) begin
                rd_word = {16'h0000, delta_ff[i][15:0]};
                rd_hit = 1'b1;
            end
            if (avs_address_i == 8'(OFS_OUTPUT_BASE + 8 * i + 4)) begin
                rd_word = {16'h0000, delta_ff[i][31:16]};
                rd_hit = 1'b1;
            end
            if (avs_address_i == 8'(OFS_GAIN_BASE + 4 * i)) begin
                rd_word = {16'h0000, gain_ff[i]};
                rd_hit = 1'b1;
            end
            if (avs_address_i == 8'(OFS_BIAS_BASE + 4 * i)) begin
                rd_word = {16'h0000, bias_ff[i]};
                rd_hit = 1'b1;
            end
        end
    end

    // Read-only words take writes silently; holes answer an error.
    assign wr_hit = rd_hit;

    // Waitrequest drops for one cycle per request.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !accept;
        end
    end

    // Read data and response are held from acceptance to completion.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_ff <= 32'h0000_0000;
            resp_ff <= RESP_OKAY;
        end else if (accept) begin
            rdata_ff <= avs_read_i ? rd_word : 32'h0000_0000;
            resp_ff <= (avs_read_i ? rd_hit : wr_hit) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Launch on completion only, so a held read fires once.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            block_read_ff <= 1'b0;
        end else begin
            block_read_ff <= done && avs_read_i
                && (avs_address_i == OFS_BLOCK_READ);
        end
    end

    // Decimation and clock select writes.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            decimation_setting_ff <= DECIMATION_RST;
            ext_sel_ff <= CONTROL_RST;
        end else if (done && avs_write_i) begin
            if (avs_address_i == OFS_DECIMATION) begin
                // A fast external clock needs a smaller setting here.
                decimation_setting_ff <= merge16(decimation_setting_ff,
                    avs_writedata_i, avs_byteenable_i);
            end
            if (avs_address_i == OFS_CONTROL && avs_byteenable_i[0]) begin
                ext_sel_ff <= avs_writedata_i[0];
            end
        end
    end

    // Internal divider; the period rounds down to whole cycles.
    assign int_tick = (tick_cnt_ff == 16'(SAMPLE_TICK_CYCLES - 1));

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick_cnt_ff <= 16'h0000;
        end else if (int_tick) begin
            tick_cnt_ff <= 16'h0000;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
        end
    end

    // External clock is synchronous; each rising edge is a sample.
    assign ext_edge = ext_clk_i && !ext_d_ff;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_d_ff <= 1'b0;
        end else begin
            ext_d_ff <= ext_clk_i;
        end
    end

    // The selected source paces the front end; the chain runs whenever the FIFO holds a sample.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sample_req_ff <= 1'b0;
        end else begin
            sample_req_ff <= ext_sel_ff ? ext_edge : int_tick;
        end
    end

    // Ready is registered, so it drops one slot early.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= (fifo_level <= ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - 2));
        end
    end

    // Samples arrive factory corrected; no register reaches that stage.
    sample_fifo #(
        .WIDTH($bits(sample_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .in_valid_i(sample_valid_i && ready_ff),
        .in_ready_o(),
        .in_data_i(sample_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data),
        .level_o(fifo_level)
    );

    // One sample leaves per three cycles, so the buffer can fill.
    assign fifo_pop = (state_ff == ST_IDLE) && fifo_valid;

    // Sequence: take a sample, correct it, integrate it.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (fifo_valid) begin
                        state_ff <= ST_CORRECT;
                    end
                end
                ST_CORRECT: begin
                    state_ff <= ST_ACCUM;
                end
                ST_ACCUM: begin
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            raw_ff <= '0;
        end else if (fifo_pop) begin
            raw_ff <= fifo_data;
        end
    end

    // Lowering the setting mid-period ends the period at the next sample.
    assign period_end = (dec_cnt_ff >= decimation_setting_ff);

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dec_cnt_ff <= 16'h0000;
        end else if (state_ff == ST_ACCUM) begin
            if (period_end) begin
                dec_cnt_ff <= 16'h0000;
            end else begin
                dec_cnt_ff <= dec_cnt_ff + 16'h0001;
            end
        end
    end

    // Per-axis user correction and trapezoid integration.
    for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
        logic signed [17:0] gain_mult; // Unity plus gain over 2^15.
        logic signed [33:0] product;
        logic signed [CORR_W-1:0] corr_val;
        logic signed [DELTA_W-1:0] pair_sum;

        assign gain_mult = 18'sh08000 + 18'(signed'(gain_ff[g]));
        assign product = signed'(raw_ff.axis[g]) * gain_mult;
        assign corr_val = CORR_W'(product >>> GAIN_FRAC)
            + CORR_W'(signed'(bias_ff[g]));
        // Each term pairs this sample with the one before it.
        assign pair_sum = DELTA_W'(signed'(corr_ff[g]))
            + DELTA_W'(signed'(prev_ff[g]));

        // Gain then bias act right behind the factory stage.
        always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
                corr_ff[g] <= '0;
            end else if (state_ff == ST_CORRECT) begin
                corr_ff[g] <= corr_val;
            end
        end

        // One sample pair per step; the 1/(2 fs) weight is the LSB.
        always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
                prev_ff[g] <= '0;
                acc_ff[g] <= '0;
            end else if (state_ff == ST_ACCUM) begin
                prev_ff[g] <= corr_ff[g];
                if (period_end) begin
                    acc_ff[g] <= '0;
                end else begin
                    acc_ff[g] <= acc_ff[g] + pair_sum;
                end
            end
        end

        // Thirty-two bits hold the nominal range at a one-second period.
        always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
                delta_ff[g] <= '0;
            end else if (state_ff == ST_ACCUM && period_end) begin
                delta_ff[g] <= acc_ff[g] + pair_sum;
            end
        end

        // User gain and bias words, one each per axis.
        always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
                gain_ff[g] <= GAIN_RST;
                bias_ff[g] <= BIAS_RST;
            end else if (done && avs_write_i) begin
                if (avs_address_i == 8'(OFS_GAIN_BASE + 4 * g)) begin
                    gain_ff[g] <= merge16(gain_ff[g], avs_writedata_i,
                        avs_byteenable_i);
                end
                if (avs_address_i == 8'(OFS_BIAS_BASE + 4 * g)) begin
                    bias_ff[g] <= merge16(bias_ff[g], avs_writedata_i,
                        avs_byteenable_i);
                end
            end
        end
    end

    // Publication strobe and result count.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ready_pulse_ff <= 1'b0;
            update_cnt_ff <= 16'h0000;
        end else begin
            ready_pulse_ff <= (state_ff == ST_ACCUM) && period_end;
            if ((state_ff == ST_ACCUM) && period_end) begin
                update_cnt_ff <= update_cnt_ff + 16'h0001;
            end
        end
    end

    assign avs_readdata_o = rdata_ff;
    assign avs_waitrequest_o = wait_ff;
    assign avs_response_o = resp_ff;
    assign sample_req_o = sample_req_ff;
    assign sample_ready_o = ready_ff;
    assign block_read_start_o = block_read_ff;
    assign data_ready_o = ready_pulse_ff;

endmodule

`default_nettype wire

// *** core/inertial_delta_pkg.sv ***
package inertial_delta_pkg;

    // Axis order: 0..2 rate x,y,z; 3..5 acceleration x,y,z.
    localparam int unsigned NUM_AXES = 6;
    localparam int unsigned NUM_RATE = 3;
    localparam int unsigned SAMPLE_W = 16;
    localparam int unsigned CORR_W = 20;
    localparam int unsigned DELTA_W = 32;
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned GAIN_FRAC = 15;

    // Clock and nominal sample rate.
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned INTERNAL_SAMPLE_RATE_HZ = 4250;
    localparam int unsigned TICK_CYCLES = CLK_HZ / INTERNAL_SAMPLE_RATE_HZ;

    // Register byte offsets.
    localparam logic [7:0] OFS_PART_NUMBER_CODE = 8'h00;
    localparam logic [7:0] OFS_DECIMATION = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_BLOCK_READ = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_OUTPUT_BASE = 8'h20;
    localparam logic [7:0] OFS_GAIN_BASE = 8'h60;
    localparam logic [7:0] OFS_BIAS_BASE = 8'h80;

    // Values after reset, and the bus response codes.
    localparam logic [15:0] DECIMATION_RST = 16'h0000;
    localparam logic [15:0] GAIN_RST = 16'h0000;
    localparam logic [15:0] BIAS_RST = 16'h0000;
    localparam logic CONTROL_RST = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // One set of six factory-corrected sensor samples.
    typedef struct packed {
        logic [NUM_AXES-1:0][SAMPLE_W-1:0] axis;
    } sample_t;

    // Correction and integration sequence.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CORRECT = 2'b01,
        ST_ACCUM = 2'b10
    } chain_state_t;

endpackage

// *** verif/inertial_delta_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// Checks bus timing, fixed reads and pulse shapes.
module inertial_delta_chk
    import inertial_delta_pkg::*;
#(
    parameter logic [15:0] PART_CODE = 16'h5a5a // Arbitrary value.
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [1:0] avs_response_o,
    input wire logic sample_req_o,
    input wire logic block_read_start_o,
    input wire logic data_ready_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    // One wait cycle per request.
    property p_answer;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=>
            !avs_waitrequest_o ##1 avs_waitrequest_o;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer timing wrong");
    property p_part;
        avs_read_i && avs_address_i == OFS_PART_NUMBER_CODE && avs_waitrequest_o |=>
            avs_readdata_o[15:0] == PART_CODE && avs_response_o == RESP_OKAY;
    endproperty
    a_part: assert property (p_part) else $error("part code read wrong");
    // Nothing lives above the bias block.
    property p_unmapped;
        (avs_read_i || avs_write_i) && avs_address_i >= 8'h98 && avs_waitrequest_o |=>
            avs_response_o == RESP_SLVERR && (avs_write_i || avs_readdata_o == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    property p_burst_go;
        avs_read_i && avs_address_i == OFS_BLOCK_READ && !avs_waitrequest_o |=>
            block_read_start_o;
    endproperty
    a_burst_go: assert property (p_burst_go) else $error("burst start missing");
    property p_burst_cause;
        block_read_start_o |-> $past(avs_read_i) && !$past(avs_waitrequest_o)
            && $past(avs_address_i) == OFS_BLOCK_READ;
    endproperty
    a_burst_cause: assert property (p_burst_cause) else $error("burst unprompted");
    property p_burst_pulse;
        block_read_start_o |=> !block_read_start_o;
    endproperty
    a_burst_pulse: assert property (p_burst_pulse) else $error("burst start too long");
    property p_dr_pulse;
        data_ready_o |=> !data_ready_o;
    endproperty
    a_dr_pulse: assert property (p_dr_pulse) else $error("data ready too long");
    property p_req_pulse;
        sample_req_o |=> !sample_req_o;
    endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("sample request too long");
endmodule

bind inertial_delta_integrator inertial_delta_chk #(.PART_CODE(PART_CODE)) chk_u (
    .clk_sys_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_readdata_o, .avs_waitrequest_o, .avs_response_o, .sample_req_o,
    .block_read_start_o, .data_ready_o
);
`default_nettype wire

// *** verif/sensor_front_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Front end model: one set of six samples per request, back to back while flood_i is high.
module sensor_front_model
    import inertial_delta_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic req_i,
    input wire logic ready_i,
    input wire sample_t value_i,
    input wire logic [3:0] lag_i,
    input wire logic flood_i,
    output logic valid_o,
    output sample_t data_o
);
    logic [4:0] lag_ff; // Cycles until the sample is offered.

    // Offer, hold until taken, then scramble released data.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            valid_o <= 1'b0;
            lag_ff <= 5'h00;
            data_o <= '0;
        end else if (valid_o) begin
            if (ready_i) begin
                valid_o <= flood_i;
                data_o <= flood_i ? value_i : ~data_o;
            end
        end else if (lag_ff == 5'h01 || flood_i) begin
            valid_o <= 1'b1;
            data_o <= value_i;
            lag_ff <= 5'h00;
        end else begin
            // Stale data never stays, so no lucky match.
            data_o <= ~data_o;
            if (req_i) begin
                lag_ff <= {1'b0, lag_i} + 5'h01;
            end else if (lag_ff != 5'h00) begin
                lag_ff <= lag_ff - 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/tb_inertial_delta_integrator.sv ***
`timescale 1ns/1ps
`default_nettype none
// Bench: bus tasks, one task per scenario, front end model.
module tb_inertial_delta_integrator
    import inertial_delta_pkg::*;
;
    localparam int TICK = 20; // Short period keeps the run brief.
    localparam logic [15:0] CODE = 16'h3c3c; // Arbitrary value.
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, sample_req_o, sample_valid_i, sample_ready_o;
    logic [1:0] avs_response_o;
    logic ext_clk_i = 1'b0;
    logic ext_run = 1'b0;
    logic flood = 1'b0;
    logic [3:0] lag = 4'h0;
    logic block_read_start_o, data_ready_o;
    sample_t sample_i, value;
    int bad_count = 0;
    int cmp_count = 0;
    int gn[6] = '{default: 0};
    int bs[6] = '{default: 0};

    function automatic int sv_of(input int i);
        return i * 700 - 1500;
    endfunction
    // Corrected sample times the trapezoid term count.
    function automatic logic [31:0] expect_res(input int i, input int mul);
        return 32'(mul * (((sv_of(i) * (32768 + gn[i])) >>> 15) + bs[i]));
    endfunction
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            value.axis[i] = 16'(sv_of(i));
        end
    end

    inertial_delta_integrator #(.SAMPLE_TICK_CYCLES(TICK), .PART_CODE(CODE)) dut_u (
        .clk_sys_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o,
        .avs_waitrequest_o, .avs_response_o, .ext_clk_i, .sample_req_o,
        .sample_valid_i, .sample_ready_o, .sample_i, .block_read_start_o,
        .data_ready_o);
    sensor_front_model front_u (
        .clk_sys_i, .nrst_i, .req_i(sample_req_o),
        .ready_i(sample_ready_o), .value_i(value), .lag_i(lag), .flood_i(flood),
        .valid_o(sample_valid_i), .data_o(sample_i));

    initial begin
        forever #20 clk_sys_i = !clk_sys_i;
    end
    // External sample clock, 30 system cycles a period.
    initial begin
        forever begin
            repeat (15) @(posedge clk_sys_i);
            if (ext_run) begin
                ext_clk_i <= !ext_clk_i;
            end
        end
    end

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One transfer, held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= !w;
        avs_write_i <= w;
        do begin
            @(posedge clk_sys_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        r = avs_response_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic wait_dr(input int k);
        repeat (k) begin
            do begin
                @(posedge clk_sys_i);
            end while (data_ready_o !== 1'b1);
        end
    endtask
    task automatic chk_all(input int mul);
        logic [31:0] lo, hi;
        logic [1:0] r;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, OFS_OUTPUT_BASE + 8'(8 * i), 32'h0, lo, r);
            bus(1'b0, OFS_OUTPUT_BASE + 8'(8 * i + 4), 32'h0, hi, r);
            cmp("result", expect_res(i, mul), {hi[15:0], lo[15:0]});
        end
    endtask
    // Gap between sample requests; the first gap is skipped.
    task automatic t_tick(input int e);
        int n;
        repeat (3) begin
            n = 0;
            do begin
                @(posedge clk_sys_i);
                n++;
            end while (sample_req_o !== 1'b1 && n < 100);
        end
        cmp("tick spacing", 32'(e), 32'(n));
    endtask
    // First result after reset pairs one sample with zero.
    task automatic t_first();
        logic [31:0] lo, hi;
        logic [1:0] r;
        wait_dr(1);
        bus(1'b0, OFS_OUTPUT_BASE, 32'h0, lo, r);
        bus(1'b0, OFS_OUTPUT_BASE + 8'h04, 32'h0, hi, r);
        cmp("first result", expect_res(0, 1), {hi[15:0], lo[15:0]});
    endtask
    task automatic t_regs();
        logic [31:0] q;
        logic [1:0] r;
        repeat (3) begin
            bus(1'b0, OFS_PART_NUMBER_CODE, 32'h0, q, r);
            cmp("part code", 32'(CODE), q);
        end
        bus(1'b1, OFS_PART_NUMBER_CODE, 32'h0000ffff, q, r);
        bus(1'b0, OFS_PART_NUMBER_CODE, 32'h0, q, r);
        cmp("part code kept", 32'(CODE), q);
        bus(1'b0, OFS_DECIMATION, 32'h0, q, r);
        cmp("decimation", 32'(DECIMATION_RST), q);
        bus(1'b0, 8'hfc, 32'h0, q, r);
        cmp("unmapped response", 32'(RESP_SLVERR), 32'(r));
        bus(1'b0, OFS_BLOCK_READ, 32'h0, q, r);
        @(posedge clk_sys_i);
        cmp("burst start", 32'h1, 32'(block_read_start_o));
    endtask
    // User gains on rate and two acceleration axes, biases on axes 1 to 5.
    task automatic t_user();
        logic [31:0] q;
        logic [1:0] r;
        for (int i = 0; i < 6; i++) begin
            gn[i] = (i < 3) ? (8192 >> i) : 4096 * (i - 3);
            bs[i] = 16 * i;
            bus(1'b1, OFS_GAIN_BASE + 8'(4 * i), 32'(gn[i]), q, r);
            bus(1'b1, OFS_BIAS_BASE + 8'(4 * i), 32'(bs[i]), q, r);
        end
        bus(1'b0, OFS_GAIN_BASE + 8'h04, 32'h0, q, r);
        cmp("gain readback", 32'h1000, q);
        wait_dr(3);
        chk_all(8);
    endtask
    task automatic t_modes();
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b1, OFS_DECIMATION, 32'h3, q, r);
        wait_dr(2);
        chk_all(8);
        t_user();
        lag <= 4'h3;
        ext_run <= 1'b1;
        bus(1'b1, OFS_DECIMATION, 32'h1, q, r);
        bus(1'b1, OFS_CONTROL, 32'h1, q, r);
        t_tick(30);
        wait_dr(2);
        chk_all(4);
    endtask
    // Flooding fills the FIFO until it refuses; then it drains.
    task automatic t_flood();
        int n;
        n = 0;
        flood <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (sample_ready_o !== 1'b0 && n < 40);
        cmp("fifo refuses", 32'h0, 32'(sample_ready_o));
        flood <= 1'b0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (sample_ready_o !== 1'b1 && n < 200);
        cmp("fifo drains", 32'h1, 32'(sample_ready_o));
    endtask
    task automatic summarize();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        t_first();
        t_tick(TICK);
        t_regs();
        t_modes();
        t_flood();
        summarize();
    end
    // Run needs about a thousand cycles; 40000 means a hang.
    initial begin
        #(40 * 40000);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
